/* pxb_unit.sv */
`timescale 1ns/10ps
`include "pxb_regs.svh"

module pxb_unit
  import pxb_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic op_valid,
  input wire pxb_op_e op_sel,
  input wire logic cond_pass,
  input wire logic [`PXB_WORD_W-1:0] first_src_reg,
  input wire logic [`PXB_WORD_W-1:0] second_src_reg,
  input wire logic [`PXB_WORD_W-1:0] dest_in,
  input wire logic [`PXB_SHAMT_W-1:0] shift_amt,
  input wire pxb_rot_e rot_sel,
  input wire logic [`PXB_SHAMT_W-1:0] field_lsb,
  input wire logic [`PXB_WIDTH_W-1:0] field_width,
  output logic [`PXB_WORD_W-1:0] result,
  output logic dest_we,
  output logic flags_we
);

  // ==========================================================
  // operand shaping
  logic [`PXB_WORD_W-1:0] rotated;
  logic [`PXB_WORD_W-1:0] lsl_val;
  logic [`PXB_WORD_W-1:0] asr_val;
  logic [`PXB_WIDTH_W-1:0] asr_amt;
  logic [`PXB_WORD_W-1:0] field_mask;
  logic [`PXB_WORD_W-1:0] low_mask;
  logic [`PXB_WORD_W-1:0] field_val;
  logic field_sign;
  logic [4:0] sign_idx;
  logic [`PXB_WORD_W-1:0] ext_byte_s;
  logic [`PXB_WORD_W-1:0] ext_byte_z;
  logic [`PXB_WORD_W-1:0] ext_half_s;
  logic [`PXB_WORD_W-1:0] ext_half_z;
  logic [`PXB_HALF_W-1:0] dual_lo_s;
  logic [`PXB_HALF_W-1:0] dual_hi_s;
  logic [`PXB_HALF_W-1:0] dual_lo_z;
  logic [`PXB_HALF_W-1:0] dual_hi_z;

  pxb_field_mask u_mask (
    .field_lsb(field_lsb),
    .field_width(field_width),
    .field_mask(field_mask),
    .low_mask(low_mask)
  );

  // rotate select zero leaves the source as it is
  always_comb begin
    case (rot_sel)
      PXB_ROT_0: rotated = second_src_reg;
      PXB_ROT_8: rotated = {second_src_reg[7:0], second_src_reg[31:8]};
      PXB_ROT_16: rotated = {second_src_reg[15:0], second_src_reg[31:16]};
      PXB_ROT_24: rotated = {second_src_reg[23:0], second_src_reg[31:24]};
      default: rotated = second_src_reg;
    endcase
  end

  // left shift amount zero is simply no shift
  assign lsl_val = second_src_reg << shift_amt;
  // an all-zero code stands for a shift of 32
  assign asr_amt = (shift_amt == '0) ? `PXB_ASR_FULL : `PXB_WIDTH_W'(shift_amt);
  assign asr_val = `PXB_WORD_W'($signed(second_src_reg) >>> asr_amt);

  assign ext_byte_s = {{24{rotated[7]}}, rotated[7:0]};
  assign ext_byte_z = {24'h000000, rotated[7:0]};
  assign ext_half_s = {{16{rotated[15]}}, rotated[15:0]};
  assign ext_half_z = {16'h0000, rotated[15:0]};
  assign dual_lo_s = {{8{rotated[7]}}, rotated[7:0]};
  assign dual_hi_s = {{8{rotated[23]}}, rotated[23:16]};
  assign dual_lo_z = {8'h00, rotated[7:0]};
  assign dual_hi_z = {8'h00, rotated[23:16]};

  // extract field brought down to bit 0
  assign field_val = (first_src_reg & field_mask) >> field_lsb;
  assign sign_idx = 5'(7'(field_lsb) + 7'(field_width) - 7'h01);
  assign field_sign = first_src_reg[sign_idx];

  // ==========================================================
  // result selection
  logic [`PXB_WORD_W-1:0] result_d;
  logic [`PXB_WORD_W-1:0] result_q;
  logic dest_we_d;
  logic dest_we_q;
  logic [`PXB_WORD_W-1:0] calc;

  always_comb begin
    case (op_sel)
      PXB_PACK_LOW_HIGH: calc = {lsl_val[31:16], first_src_reg[15:0]};
      PXB_PACK_HIGH_LOW: calc = {first_src_reg[31:16], asr_val[15:0]};
      PXB_SIGN_EXT_BYTE_ACCUM: calc = first_src_reg + ext_byte_s;
      PXB_SIGN_EXT_HALF_ACCUM: calc = first_src_reg + ext_half_s;
      PXB_ZERO_EXT_BYTE_ACCUM: calc = first_src_reg + ext_byte_z;
      PXB_ZERO_EXT_HALF_ACCUM: calc = first_src_reg + ext_half_z;
      PXB_SIGN_EXT_DUAL_BYTE_ACCUM: begin
        calc = {first_src_reg[31:16] + dual_hi_s, first_src_reg[15:0] + dual_lo_s};
      end
      PXB_ZERO_EXT_DUAL_BYTE_ACCUM: begin
        calc = {first_src_reg[31:16] + dual_hi_z, first_src_reg[15:0] + dual_lo_z};
      end
      PXB_SIGN_EXT_BYTE: calc = ext_byte_s;
      PXB_SIGN_EXT_HALF: calc = ext_half_s;
      PXB_ZERO_EXT_BYTE: calc = ext_byte_z;
      PXB_ZERO_EXT_HALF: calc = ext_half_z;
      PXB_SIGN_EXT_DUAL_BYTE: calc = {dual_hi_s, dual_lo_s};
      PXB_ZERO_EXT_DUAL_BYTE: calc = {dual_hi_z, dual_lo_z};
      PXB_FIELD_CLEAR: calc = dest_in & ~field_mask;
      PXB_FIELD_INSERT: calc = (dest_in & ~field_mask) | ((first_src_reg << field_lsb) & field_mask);
      PXB_SIGNED_FIELD_EXTRACT: calc = field_sign ? (field_val | ~low_mask) : field_val;
      PXB_UNSIGNED_FIELD_EXTRACT: calc = field_val;
      default: calc = `PXB_RESULT_RST;
    endcase
  end

  // a failed condition keeps the old result and raises no write
  always_comb begin
    result_d = result_q;
    dest_we_d = 1'b0;
    if (op_valid && cond_pass) begin
      result_d = calc;
      dest_we_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      result_q <= `PXB_RESULT_RST;
      dest_we_q <= 1'b0;
    end else begin
      result_q <= result_d;
      dest_we_q <= dest_we_d;
    end
  end

  assign result = result_q;
  assign dest_we = dest_we_q;
  // no operation of this unit writes the condition flags
  assign flags_we = 1'b0;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_go(pxb_op_e o);
    op_valid && cond_pass && op_sel == o;
  endsequence

  sequence s_field(pxb_op_e o, logic [4:0] l, logic [5:0] w);
    s_go(o) ##0 field_lsb == l && field_width == w;
  endsequence

  sequence s_rot(pxb_op_e o, pxb_rot_e r);
    s_go(o) ##0 rot_sel == r;
  endsequence

  sequence s_shift(pxb_op_e o, logic [4:0] s);
    s_go(o) ##0 shift_amt == s;
  endsequence

  a_pack_low_half: assert property (
    s_go(PXB_PACK_LOW_HIGH) |=> dest_we && result[15:0] == $past(first_src_reg[15:0]))
    else $error("pack low half not taken from first source");

  a_pack_no_shift: assert property (
    s_go(PXB_PACK_LOW_HIGH) ##0 shift_amt == 5'h00 |=> result[31:16] == $past(second_src_reg[31:16]))
    else $error("unshifted pack top half wrong");

  a_pack_high_top: assert property (
    s_go(PXB_PACK_HIGH_LOW) |=> result[31:16] == $past(first_src_reg[31:16]))
    else $error("pack high half not taken from first source");

  a_pack_asr_full: assert property (
    s_go(PXB_PACK_HIGH_LOW) ##0 shift_amt == 5'h00 |=> result[15:0] == {16{$past(second_src_reg[31])}})
    else $error("zero shift code not treated as 32");

  a_ext_rotate_half: assert property (
    s_go(PXB_ZERO_EXT_HALF) ##0 rot_sel == PXB_ROT_16 |=> result == {16'h0000, $past(second_src_reg[31:16])})
    else $error("rotate by 16 before extend wrong");

  a_ext_byte_zero: assert property (
    s_go(PXB_ZERO_EXT_BYTE) ##0 rot_sel == PXB_ROT_0 |=> result == {24'h000000, $past(second_src_reg[7:0])})
    else $error("zero byte extend wrong");

  a_accum_word: assert property (
    s_go(PXB_SIGN_EXT_HALF_ACCUM) ##0 rot_sel == PXB_ROT_0
    |=> result == $past(first_src_reg) + {{16{$past(second_src_reg[15])}}, $past(second_src_reg[15:0])})
    else $error("half accumulate sum wrong");

  a_field_clear: assert property (
    s_go(PXB_FIELD_CLEAR) |=> result == ($past(dest_in) & ~$past(field_mask)))
    else $error("field clear result wrong");

  a_unsigned_extract: assert property (
    s_field(PXB_UNSIGNED_FIELD_EXTRACT, 5'h00, 6'h08) |=> result == {24'h000000, $past(first_src_reg[7:0])})
    else $error("unsigned extract of low byte wrong");

  a_cond_fail: assert property (
    op_valid && !cond_pass |=> !dest_we && $stable(result))
    else $error("write on failed condition");

  a_flags_quiet: assert property (
    op_valid |-> !flags_we ##1 !flags_we)
    else $error("condition flags written");

  a_pack_shift_top: assert property (
    s_shift(PXB_PACK_LOW_HIGH, 5'h10) |=> result[31:16] == $past(second_src_reg[15:0]))
    else $error("shifted pack top half wrong");

  a_pack_asr_one: assert property (
    s_shift(PXB_PACK_HIGH_LOW, 5'h01) |=> result[15:0] == $past(second_src_reg[16:1]))
    else $error("pack right shift by one wrong");

  a_pack_asr_half: assert property (
    s_shift(PXB_PACK_HIGH_LOW, 5'h10) |=> result[15:0] == $past(second_src_reg[31:16]))
    else $error("pack right shift by sixteen wrong");

  a_ext_no_rotate: assert property (
    s_rot(PXB_SIGN_EXT_HALF, PXB_ROT_0)
    |=> result == {{16{$past(second_src_reg[15])}}, $past(second_src_reg[15:0])})
    else $error("unrotated half extend wrong");

  a_sext_byte_accum: assert property (
    s_rot(PXB_SIGN_EXT_BYTE_ACCUM, PXB_ROT_8)
    |=> result == $past(first_src_reg) + {{24{$past(second_src_reg[15])}}, $past(second_src_reg[15:8])})
    else $error("signed byte accumulate wrong");

  a_zext_byte_accum: assert property (
    s_rot(PXB_ZERO_EXT_BYTE_ACCUM, PXB_ROT_24)
    |=> result == $past(first_src_reg) + {24'h000000, $past(second_src_reg[31:24])})
    else $error("unsigned byte accumulate wrong");

  a_zext_half_accum: assert property (
    s_rot(PXB_ZERO_EXT_HALF_ACCUM, PXB_ROT_8)
    |=> result == $past(first_src_reg) + {16'h0000, $past(second_src_reg[23:8])})
    else $error("unsigned half accumulate wrong");

  a_dual_low_accum: assert property (
    s_rot(PXB_SIGN_EXT_DUAL_BYTE_ACCUM, PXB_ROT_0)
    |=> result[15:0] == $past(first_src_reg[15:0]) + {{8{$past(second_src_reg[7])}}, $past(second_src_reg[7:0])})
    else $error("dual accumulate low half wrong");

  a_dual_high_accum: assert property (
    s_rot(PXB_SIGN_EXT_DUAL_BYTE_ACCUM, PXB_ROT_0)
    |=> result[31:16] == $past(first_src_reg[31:16]) + {{8{$past(second_src_reg[23])}}, $past(second_src_reg[23:16])})
    else $error("dual accumulate high half wrong");

  a_zext_dual_accum: assert property (
    s_rot(PXB_ZERO_EXT_DUAL_BYTE_ACCUM, PXB_ROT_8)
    |=> result == {$past(first_src_reg[31:16]) + {8'h00, $past(second_src_reg[31:24])},
                   $past(first_src_reg[15:0]) + {8'h00, $past(second_src_reg[15:8])}})
    else $error("unsigned dual accumulate wrong");

  a_sext_half_plain: assert property (
    s_rot(PXB_SIGN_EXT_HALF, PXB_ROT_24)
    |=> result == {{16{$past(second_src_reg[7])}}, $past(second_src_reg[7:0]), $past(second_src_reg[31:24])})
    else $error("rotated half extend wrong");

  a_sext_byte_plain: assert property (
    s_rot(PXB_SIGN_EXT_BYTE, PXB_ROT_16)
    |=> result == {{24{$past(second_src_reg[23])}}, $past(second_src_reg[23:16])})
    else $error("rotated byte extend wrong");

  a_dual_zext_plain: assert property (
    s_rot(PXB_ZERO_EXT_DUAL_BYTE, PXB_ROT_16)
    |=> result == {8'h00, $past(second_src_reg[7:0]), 8'h00, $past(second_src_reg[23:16])})
    else $error("unsigned dual extend wrong");

  a_dual_sext_plain: assert property (
    s_rot(PXB_SIGN_EXT_DUAL_BYTE, PXB_ROT_0)
    |=> result == {{8{$past(second_src_reg[23])}}, $past(second_src_reg[23:16]),
                   {8{$past(second_src_reg[7])}}, $past(second_src_reg[7:0])})
    else $error("signed dual extend wrong");

  a_clear_nibble: assert property (
    s_field(PXB_FIELD_CLEAR, 5'h04, 6'h04) |=> result == {$past(dest_in[31:8]), 4'h0, $past(dest_in[3:0])})
    else $error("field clear of nibble wrong");

  a_insert_nibble: assert property (
    s_field(PXB_FIELD_INSERT, 5'h04, 6'h04)
    |=> result == {$past(dest_in[31:8]), $past(first_src_reg[3:0]), $past(dest_in[3:0])})
    else $error("field insert of nibble wrong");

  a_insert_top: assert property (
    s_field(PXB_FIELD_INSERT, 5'h1c, 6'h04) |=> result == {$past(first_src_reg[3:0]), $past(dest_in[27:0])})
    else $error("field insert at top wrong");

  a_signed_extract: assert property (
    s_field(PXB_SIGNED_FIELD_EXTRACT, 5'h04, 6'h04)
    |=> result == {{28{$past(first_src_reg[7])}}, $past(first_src_reg[7:4])})
    else $error("signed extract of nibble wrong");

  a_signed_top_bit: assert property (
    s_field(PXB_SIGNED_FIELD_EXTRACT, 5'h1f, 6'h01) |=> result == {32{$past(first_src_reg[31])}})
    else $error("signed extract of top bit wrong");

  a_unsigned_mid: assert property (
    s_field(PXB_UNSIGNED_FIELD_EXTRACT, 5'h09, 6'h0a) |=> result == {22'h000000, $past(first_src_reg[18:9])})
    else $error("unsigned extract of middle field wrong");

  a_field_flags: assert property (
    op_valid && op_sel inside {PXB_FIELD_CLEAR, PXB_FIELD_INSERT} |=> !flags_we)
    else $error("field operation wrote flags");

  a_write_pulse: assert property (
    op_valid && cond_pass |=> dest_we)
    else $error("accepted operation gave no write");

  a_idle_quiet: assert property (
    !op_valid |=> !dest_we && $stable(result))
    else $error("write without an operation");

endmodule : pxb_unit

/* pxb_regs.svh */
`ifndef PXB_REGS_SVH
`define PXB_REGS_SVH

`define PXB_WORD_W 32
`define PXB_HALF_W 16
`define PXB_BYTE_W 8
`define PXB_SHAMT_W 5
`define PXB_WIDTH_W 6
`define PXB_ASR_FULL 6'h20
`define PXB_RESULT_RST 32'h0000_0000
`define PXB_LATENCY 1

`endif

/* pxb_pkg.sv */
package pxb_pkg;

  typedef enum logic [4:0] {
    PXB_PACK_LOW_HIGH = 5'h00,
    PXB_PACK_HIGH_LOW = 5'h01,
    PXB_SIGN_EXT_BYTE_ACCUM = 5'h02,
    PXB_SIGN_EXT_HALF_ACCUM = 5'h03,
    PXB_SIGN_EXT_DUAL_BYTE_ACCUM = 5'h04,
    PXB_ZERO_EXT_BYTE_ACCUM = 5'h05,
    PXB_ZERO_EXT_HALF_ACCUM = 5'h06,
    PXB_ZERO_EXT_DUAL_BYTE_ACCUM = 5'h07,
    PXB_SIGN_EXT_BYTE = 5'h08,
    PXB_SIGN_EXT_HALF = 5'h09,
    PXB_SIGN_EXT_DUAL_BYTE = 5'h0a,
    PXB_ZERO_EXT_BYTE = 5'h0b,
    PXB_ZERO_EXT_HALF = 5'h0c,
    PXB_ZERO_EXT_DUAL_BYTE = 5'h0d,
    PXB_FIELD_CLEAR = 5'h0e,
    PXB_FIELD_INSERT = 5'h0f,
    PXB_SIGNED_FIELD_EXTRACT = 5'h10,
    PXB_UNSIGNED_FIELD_EXTRACT = 5'h11
  } pxb_op_e;

  typedef enum logic [1:0] {
    PXB_ROT_0 = 2'h0,
    PXB_ROT_8 = 2'h1,
    PXB_ROT_16 = 2'h2,
    PXB_ROT_24 = 2'h3
  } pxb_rot_e;

endpackage : pxb_pkg

/* pxb_field_mask.sv */
`timescale 1ns/10ps
`include "pxb_regs.svh"

// ==========================================================
// field mask: ones from lsb up to lsb+width-1
module pxb_field_mask (
  input wire logic [`PXB_SHAMT_W-1:0] field_lsb,
  input wire logic [`PXB_WIDTH_W-1:0] field_width,
  output logic [`PXB_WORD_W-1:0] field_mask,
  output logic [`PXB_WORD_W-1:0] low_mask
);

  logic [6:0] field_top;

  // widths past the word top are cut at bit 31
  assign field_top = 7'(field_lsb) + 7'(field_width);

  genvar gi;
  generate
    for (gi = 0; gi < `PXB_WORD_W; gi++) begin : g_bit
      assign field_mask[gi] = (7'(gi) >= 7'(field_lsb)) && (7'(gi) < field_top);
      assign low_mask[gi] = 7'(gi) < 7'(field_width);
    end
  endgenerate

endmodule : pxb_field_mask

/* pxb_decode_model.sv */
`timescale 1ns/10ps
`include "pxb_regs.svh"

// ==========================================================
// decode stage and register file stand-in
module pxb_decode_model
  import pxb_pkg::*;
(
  input wire logic clk,
  output logic op_valid,
  output pxb_op_e op_sel,
  output logic cond_pass,
  output logic [`PXB_WORD_W-1:0] first_src_reg,
  output logic [`PXB_WORD_W-1:0] second_src_reg,
  output logic [`PXB_WORD_W-1:0] dest_in,
  output logic [`PXB_SHAMT_W-1:0] shift_amt,
  output pxb_rot_e rot_sel,
  output logic [`PXB_SHAMT_W-1:0] field_lsb,
  output logic [`PXB_WIDTH_W-1:0] field_width
);
  initial begin
    op_valid = 1'b0;
    op_sel = PXB_PACK_LOW_HIGH;
    cond_pass = 1'b0;
    first_src_reg = 32'h0;
    second_src_reg = 32'h0;
    dest_in = 32'h0;
    shift_amt = 5'h0;
    rot_sel = PXB_ROT_0;
    field_lsb = 5'h0;
    field_width = 6'h1;
  end

  // operands only ever come from general registers
  task automatic issue(input pxb_op_e op, input logic c, input logic [31:0] a, input logic [31:0] b,
      input logic [31:0] d, input logic [4:0] sh, input pxb_rot_e rt, input logic [4:0] l, input logic [5:0] w);
    @(posedge clk);
    op_valid <= 1'b1;
    op_sel <= op;
    cond_pass <= c;
    first_src_reg <= a;
    second_src_reg <= b;
    dest_in <= d;
    shift_amt <= sh;
    rot_sel <= rt;
    field_lsb <= l;
    field_width <= (w > 6'h20 - {1'b0, l}) ? 6'h20 - {1'b0, l} : w;
  endtask

  // operands scramble while nothing is presented
  task automatic idle();
    @(posedge clk);
    op_valid <= 1'b0;
    cond_pass <= ~cond_pass;
    first_src_reg <= ~first_src_reg;
    second_src_reg <= ~second_src_reg;
    dest_in <= ~dest_in;
  endtask
endmodule : pxb_decode_model

/* test_pack_extend_bitfield_unit.sv */
`timescale 1ns/10ps
`include "pxb_regs.svh"

module test_pack_extend_bitfield_unit import pxb_pkg::*;;
  logic clk, srst, op_valid, cond_pass, dest_we, flags_we;
  pxb_op_e op_sel;
  pxb_rot_e rot_sel;
  logic [31:0] first_src_reg, second_src_reg, dest_in, result;
  logic [4:0] shift_amt, field_lsb;
  logic [5:0] field_width;
  logic [31:0] dv = 32'h5a5a_a5a5;
  int fails = 0;
  int samples_checked = 0;

  pxb_unit pxb_unit_inst (.clk(clk), .srst(srst), .op_valid(op_valid), .op_sel(op_sel), .cond_pass(cond_pass),
    .first_src_reg(first_src_reg), .second_src_reg(second_src_reg), .dest_in(dest_in), .shift_amt(shift_amt),
    .rot_sel(rot_sel), .field_lsb(field_lsb), .field_width(field_width), .result(result), .dest_we(dest_we),
    .flags_we(flags_we));
  pxb_decode_model pxb_decode_model_inst (.clk(clk), .op_valid(op_valid), .op_sel(op_sel), .cond_pass(cond_pass),
    .first_src_reg(first_src_reg), .second_src_reg(second_src_reg), .dest_in(dest_in), .shift_amt(shift_amt),
    .rot_sel(rot_sel), .field_lsb(field_lsb), .field_width(field_width));

  // ==========================================================
  // expected values and compares
  function automatic logic [31:0] ref_result(input pxb_op_e op, input logic [31:0] a, input logic [31:0] b,
      input logic [4:0] sh, input pxb_rot_e rt, input logic [4:0] l, input logic [5:0] w);
    logic [63:0] bb;
    logic [31:0] r, k, m, v, sl, sr;
    logic [15:0] lo, hi;
    logic sg;
    bb = {b, b} >> (8 * rt);
    r = bb[31:0];
    k = 32'((33'h1 << w) - 33'h1);
    m = k << l;
    sg = op inside {PXB_SIGN_EXT_DUAL_BYTE_ACCUM, PXB_SIGN_EXT_DUAL_BYTE};
    lo = sg ? {{8{r[7]}}, r[7:0]} : {8'h0, r[7:0]};
    hi = sg ? {{8{r[23]}}, r[23:16]} : {8'h0, r[23:16]};
    v = (a >> l) & k;
    sl = b << sh;
    sr = $signed(b) >>> ((sh == 5'h0) ? 6'h20 : {1'b0, sh});
    case (op)
      PXB_PACK_LOW_HIGH: return {sl[31:16], a[15:0]};
      PXB_PACK_HIGH_LOW: return {a[31:16], sr[15:0]};
      PXB_SIGN_EXT_BYTE_ACCUM: return a + {{24{r[7]}}, r[7:0]};
      PXB_SIGN_EXT_HALF_ACCUM: return a + {{16{r[15]}}, r[15:0]};
      PXB_ZERO_EXT_BYTE_ACCUM: return a + {24'h0, r[7:0]};
      PXB_ZERO_EXT_HALF_ACCUM: return a + {16'h0, r[15:0]};
      PXB_SIGN_EXT_DUAL_BYTE_ACCUM, PXB_ZERO_EXT_DUAL_BYTE_ACCUM: return {a[31:16] + hi, a[15:0] + lo};
      PXB_SIGN_EXT_BYTE: return {{24{r[7]}}, r[7:0]};
      PXB_SIGN_EXT_HALF: return {{16{r[15]}}, r[15:0]};
      PXB_ZERO_EXT_BYTE: return {24'h0, r[7:0]};
      PXB_ZERO_EXT_HALF: return {16'h0, r[15:0]};
      PXB_SIGN_EXT_DUAL_BYTE, PXB_ZERO_EXT_DUAL_BYTE: return {hi, lo};
      PXB_FIELD_CLEAR: return dv & ~m;
      PXB_FIELD_INSERT: return (dv & ~m) | ((a << l) & m);
      PXB_SIGNED_FIELD_EXTRACT: return v[w - 6'h1] ? v | ~k : v;
      default: return v;
    endcase
  endfunction : ref_result

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic go(input pxb_op_e op, input logic [4:0] sh, input pxb_rot_e rt, input logic [4:0] l,
      input logic [5:0] w, input logic [31:0] a = 32'hc3e1_9b74, input logic [31:0] b = 32'h80a5_7f36);
    pxb_decode_model_inst.issue(op, 1'b1, a, b, dv, sh, rt, l, w);
    pxb_decode_model_inst.idle();
    #1;
    chk_bit("dest_we", 1'b1, dest_we);
    chk_bit("flags_we", 1'b0, flags_we);
    chk_word(op.name(), ref_result(op, a, b, sh, rt, l, w), result);
    @(posedge clk);
    #1;
    chk_bit("dest_we", 1'b0, dest_we);
  endtask : go

  // ==========================================================
  // scenarios
  task automatic t_reset();
    #1;
    chk_word("result", 32'h0, result);
    chk_bit("dest_we", 1'b0, dest_we);
    chk_bit("flags_we", 1'b0, flags_we);
  endtask : t_reset

  task automatic t_all_ops();
    logic [4:0] s[4] = '{5'h0, 5'h1, 5'h1f, 5'h10};
    logic [4:0] lv[4] = '{5'h0, 5'h4, 5'h1f, 5'h9};
    logic [5:0] wv[4] = '{6'h20, 6'h4, 6'h1, 6'ha};
    for (int i = 0; i < 18; i++) begin
      for (int k = 0; k < 4; k++) begin
        go(pxb_op_e'(i), s[k], pxb_rot_e'(k), lv[k], wv[k]);
      end
    end
  endtask : t_all_ops

  task automatic t_cond_fail();
    go(PXB_ZERO_EXT_HALF, 5'h0, PXB_ROT_8, 5'h0, 6'h1);
    pxb_decode_model_inst.issue(PXB_FIELD_CLEAR, 1'b0, 32'h0, 32'h0, dv, 5'h0, PXB_ROT_0, 5'h0, 6'h20);
    pxb_decode_model_inst.idle();
    #1;
    chk_bit("dest_we", 1'b0, dest_we);
    chk_word("held", 32'h0000_a57f, result);
  endtask : t_cond_fail

  task automatic t_back();
    pxb_decode_model_inst.issue(PXB_PACK_HIGH_LOW, 1'b1, 32'h1234_5678, 32'h8000_0000, dv, 5'h0, PXB_ROT_0, 5'h0, 6'h1);
    pxb_decode_model_inst.issue(PXB_FIELD_INSERT, 1'b1, 32'h0000_000f, 32'h0, dv, 5'h0, PXB_ROT_0, 5'h1c, 6'h4);
    #1;
    chk_word("pack", 32'h1234_ffff, result);
    pxb_decode_model_inst.idle();
    #1;
    chk_bit("dest_we", 1'b1, dest_we);
    chk_word("insert", 32'hfa5a_a5a5, result);
    go(PXB_UNSIGNED_FIELD_EXTRACT, 5'h0, PXB_ROT_0, 5'h0, 6'h08);
  endtask : t_back

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    srst = 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_all_ops();
    t_cond_fail();
    t_back();
    conclude();
  end
endmodule : test_pack_extend_bitfield_unit
